// ===== boot_lock_and_fuse5_guard.sv
`timescale 1ns/1ps
module boot_lock_and_fuse5_guard
	import fuse_lock_pkg::*;
#(
	parameter int AW          = 16,
	parameter int FUSE_WR_CNT = FUSE_WR_CYC
) (
	input  wire logic          i_mclk,
	input  wire logic          i_arst_n,
	// avalon-mm slave
	input  wire logic [3:0]    i_address,
	input  wire logic          i_read,
	input  wire logic          i_write,
	input  wire logic [31:0]   i_writedata,
	input  wire logic [3:0]    i_byteenable,
	output logic [31:0]        o_readdata,
	output logic               o_waitrequest,
	// section layout
	input  wire logic [AW-1:0] i_table_start,
	input  wire logic [AW-1:0] i_boot_start,
	input  wire logic          i_vectors_in_boot,
	// core access port
	input  wire logic [AW-1:0] i_pm_addr,
	input  wire logic          i_pm_store,
	input  wire logic          i_pm_load,
	input  wire logic          i_exec_in_boot,
	output logic               o_pm_grant,
	output logic               o_pm_block,
	output logic               o_irq_mask,
	// erase strobes
	output logic               o_erase_flash,
	output logic               o_erase_eeprom,
	output logic               o_erase_sram,
	// brownout settings
	output logic [1:0]         o_brownout_active_op,
	output logic               o_brownout_sampled,
	output logic               o_brownout_continuous,
	output logic [2:0]         o_brownout_threshold_sel
);
	typedef struct packed {
		logic [7:0]  fuse5;        // committed fuse byte
		logic [7:0]  fuse5_pend;   // value being written
		logic [7:0]  lock;
		logic        ack;
		logic [31:0] rdata;
		logic        grant;
		logic        block;
		logic        irq_mask;
		logic        er_flash;
		logic        er_ee;
		logic        er_sram;
		logic [1:0]  bod_act;
		logic        bod_samp;
		logic        bod_cont;
		logic [2:0]  bod_lvl;
	} st_t;
	st_t s_r, s_nxt;

	logic fuse_busy;
	logic fuse_done;
	logic blk;
	logic start_fuse;
	logic wr_hit;

	// ----------------------------------------
	// sub blocks
	// ----------------------------------------
	fuse_timer #(
		.CYC      (FUSE_WR_CNT)
	) u_timer (
		.i_mclk   (i_mclk),
		.i_arst_n (i_arst_n),
		.i_start  (start_fuse),
		.o_busy   (fuse_busy),
		.o_done   (fuse_done)
	);

	section_decode #(
		.AW            (AW)
	) u_dec (
		.i_addr        (i_pm_addr),
		.i_table_start (i_table_start),
		.i_boot_start  (i_boot_start),
		.i_lock        (s_r.lock),
		.i_from_boot   (i_exec_in_boot),
		.i_store       (i_pm_store),
		.i_load        (i_pm_load),
		.o_block       (blk)
	);

	// one-cycle answer: accept on first cycle, ack drops waitrequest next
	assign wr_hit = i_write && !s_r.ack;
	// fuse byte lives in lane 1, so the bus sees it at its word address
	assign start_fuse = wr_hit && (i_address == (FUSE5_OFS & 4'hC)) && i_byteenable[1] && !fuse_busy;

	// ----------------------------------------
	// next state
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.ack = (i_read || i_write) && !s_r.ack;
		s_nxt.er_flash = 1'b0;
		s_nxt.er_ee = 1'b0;
		s_nxt.er_sram = 1'b0;

		// fuse byte sits in lane 1 of word 4; reserved bits forced high
		if (start_fuse)
			s_nxt.fuse5_pend = {FUSE5_RSV_ONES, i_writedata[13:8]};
		// committed only when the write timeout runs out
		if (fuse_done)
			s_nxt.fuse5 = s_r.fuse5_pend;

		// and-merge so bits only fall toward tighter locking
		if (wr_hit && i_address == LOCK_OFS && i_byteenable[0])
			s_nxt.lock = s_r.lock & (i_writedata[7:0] | ~LOCK_FIELD_MSK);

		// chip erase; erase wins over a same-cycle lock write
		if (wr_hit && i_address == CTRL_OFS && i_byteenable[0] && i_writedata[CTRL_ERASE_BIT]) begin
			s_nxt.er_flash = 1'b1;
			s_nxt.er_sram = 1'b1;
			s_nxt.er_ee = s_r.fuse5[EE_KEEP_POS];
			s_nxt.lock = LOCK_RESET;
		end

		// read mux; unmapped words read zero
		if (i_read && !s_r.ack) begin
			unique case (i_address)
				STATUS_OFS: s_nxt.rdata = {24'h0, s_r.lock};
				// busy covers the commit cycle so idle always means the new value rules
				FUSE5_OFS & 4'hC: s_nxt.rdata = {16'h0, s_r.fuse5, 7'h0, fuse_busy | fuse_done};
				LOCK_OFS:   s_nxt.rdata = {24'h0, s_r.lock};
				default:    s_nxt.rdata = 32'h0;
			endcase
		end

		// access check; interrupts masked while running in a locked-out section that does not hold the vectors
		s_nxt.block = (i_pm_store || i_pm_load) && blk;
		s_nxt.grant = (i_pm_store || i_pm_load) && !blk;
		if (i_vectors_in_boot)
			s_nxt.irq_mask = !i_exec_in_boot
				&& (!s_r.lock[APP_LOCK_POS + 1] || !s_r.lock[TBL_LOCK_POS + 1]);
		else
			s_nxt.irq_mask = i_exec_in_boot && !s_r.lock[BOOT_LOCK_POS + 1];

		// brownout settings follow the committed fuse
		s_nxt.bod_act = s_r.fuse5[BOD_ACT_POS +: 2];
		s_nxt.bod_samp = (s_r.fuse5[BOD_ACT_POS +: 2] == BOD_SAMPLED);
		s_nxt.bod_cont = (s_r.fuse5[BOD_ACT_POS +: 2] == BOD_CONTINUOUS);
		s_nxt.bod_lvl = s_r.fuse5[BOD_LVL_POS +: 3];
	end

	// ----------------------------------------
	// state register
	// ----------------------------------------
	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			s_r <= '0;
			s_r.fuse5 <= FUSE5_RESET;
			s_r.fuse5_pend <= FUSE5_RESET;
			s_r.lock <= LOCK_RESET;
			s_r.bod_act <= BOD_OFF;
			s_r.bod_lvl <= 3'h7;
		end else begin
			s_r <= s_nxt;
		end
	end

	// ----------------------------------------
	// outputs, all registered
	// ----------------------------------------
	assign o_waitrequest = !s_r.ack;
	assign o_readdata = s_r.rdata;
	assign o_pm_grant = s_r.grant;
	assign o_pm_block = s_r.block;
	assign o_irq_mask = s_r.irq_mask;
	assign o_erase_flash = s_r.er_flash;
	assign o_erase_eeprom = s_r.er_ee;
	assign o_erase_sram = s_r.er_sram;
	assign o_brownout_active_op = s_r.bod_act;
	assign o_brownout_sampled = s_r.bod_samp;
	assign o_brownout_continuous = s_r.bod_cont;
	assign o_brownout_threshold_sel = s_r.bod_lvl;
endmodule : boot_lock_and_fuse5_guard

// ===== boot_lock_and_fuse5_guard_tb.sv
`timescale 1ns/1ps
module boot_lock_and_fuse5_guard_tb
	import fuse_lock_pkg::*;
;
	logic        i_mclk, i_arst_n, i_read, i_write, i_vectors_in_boot, i_pm_store, i_pm_load, i_exec_in_boot;
	logic        o_waitrequest, o_pm_grant, o_pm_block, o_irq_mask, o_erase_flash, o_erase_eeprom, o_erase_sram;
	logic        o_brownout_sampled, o_brownout_continuous, blk, irq;
	logic [1:0]  o_brownout_active_op, c;
	logic [2:0]  o_brownout_threshold_sel;
	logic [3:0]  i_address, i_byteenable;
	logic [7:0]  f, lv[3], le[3];
	logic [15:0] i_table_start, i_boot_start, i_pm_addr, sa[3];
	logic [31:0] i_writedata, o_readdata, q;
	int          err_total, n_tests, n_ee, n_fl, p;

	boot_lock_and_fuse5_guard #(.FUSE_WR_CNT(4)) u_dut (.*);
	core_model u_core (.i_mclk(i_mclk), .i_pm_block(o_pm_block), .i_irq_mask(o_irq_mask), .o_pm_addr(i_pm_addr),
		.o_pm_store(i_pm_store), .o_pm_load(i_pm_load), .o_exec_in_boot(i_exec_in_boot));

	always #4 i_mclk = ~i_mclk;
	// count strobes so checks need not hit the exact cycle
	always @(posedge i_mclk) begin
		n_fl <= n_fl + int'(o_erase_flash);
		n_ee <= n_ee + int'(o_erase_eeprom);
	end

	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("Error %0t: got %h want %h", $time, seen, exp);
		end
	endtask : chk

	task automatic conclude;
		$display("checks %0d errors %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask : conclude

	// avalon cycle: hold until waitrequest seen low
	task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d, input logic [3:0] b);
		int n;
		n = 0;
		@(posedge i_mclk);
		i_read <= !w;
		i_write <= w;
		i_address <= a;
		i_writedata <= d;
		i_byteenable <= b;
		do begin
			@(posedge i_mclk);
			n++;
		end while (o_waitrequest !== 1'b0 && n < 50);
		q = o_readdata;
		i_read <= 1'b0;
		i_write <= 1'b0;
		if (o_waitrequest !== 1'b0) begin
			err_total++;
			conclude();
		end
	endtask : bus

	task automatic erase;
		bus(1'b1, CTRL_OFS, 32'h1, 4'h1);
	endtask : erase

	// ------------------------------
	// main sequence
	// ------------------------------
	initial begin
		{i_mclk, i_arst_n, i_read, i_write, i_vectors_in_boot} = '0;
		{i_address, i_byteenable, i_writedata, err_total, n_tests, n_ee, n_fl} = '0;
		i_table_start = 16'h8000;
		i_boot_start = 16'hC000;
		sa = '{16'hD000, 16'h1000, 16'h9000};
		lv = '{8'hBF, 8'h7F, 8'hFF};
		le = '{8'hBF, 8'h3F, 8'h3F};
		repeat (20) @(posedge i_mclk);
		i_arst_n <= 1'b1;
		bus(1'b0, 4'h4, 32'h0, 4'hF);
		chk(q[15:0], 16'hFF00);
		chk(o_brownout_active_op, BOD_OFF);
		chk(o_brownout_threshold_sel, 3'h7);
		bus(1'b0, 4'h2, 32'h0, 4'hF);
		chk(q, 32'h0);
		// reserved bits always written high; keep bit flips both ways
		foreach (le[i]) begin
			f = (i == 0) ? 8'hD2 : (i == 1) ? 8'hF8 : 8'hE5;
			bus(1'b1, 4'h4, {16'h0, f, 8'h00}, 4'h2);
			// poll the busy bit; the write's own q is stale and must not end the wait
			p = 0;
			do begin
				bus(1'b0, 4'h4, 32'h0, 4'hF);
				p++;
			end while (q[0] !== 1'b0 && p < 20);
			chk(q[0], 1'b0);
			bus(1'b0, 4'h4, 32'h0, 4'hF);
			chk(q[15:8], f);
			chk(o_brownout_active_op, f[5:4]);
			chk({o_brownout_sampled, o_brownout_continuous}, {f[5:4] == 2'h1, f[5:4] == 2'h2});
			chk(o_brownout_threshold_sel, f[2:0]);
			p = n_ee;
			c = 2'(n_fl);
			erase();
			bus(1'b0, LOCK_OFS, 32'h0, 4'hF);
			chk(2'(2'(n_fl) - c), 2'h1);
			chk(n_ee - p, f[3]);
		end
		// loosening is refused, bits only fall
		foreach (lv[i]) begin
			bus(1'b1, LOCK_OFS, {24'h0, lv[i]}, 4'h1);
			bus(1'b0, LOCK_OFS, 32'h0, 4'hF);
			chk(q[7:0], le[i]);
		end
		erase();
		bus(1'b0, LOCK_OFS, 32'h0, 4'hF);
		chk(q[7:0], 8'hFF);
		// every code of every section: store, cross load, own load
		for (int s = 0; s < 3; s++)
			for (int k = 0; k < 4; k++) begin
				c = 2'(k);
				p = 6 - 2 * s;
				erase();
				i_vectors_in_boot <= (s != 0);
				bus(1'b1, LOCK_OFS, 32'((8'hFF & ~(8'h3 << p)) | (8'(c) << p)), 4'h1);
				u_core.access(sa[s], 1'b1, 1'b0, blk, irq);
				chk(blk, !c[0]);
				u_core.access(sa[s], 1'b0, s != 0, blk, irq);
				chk({blk, irq}, {!c[1], 1'b0});
				u_core.access(sa[s], 1'b0, s == 0, blk, irq);
				chk({blk, irq}, {1'b0, !c[1]});
			end
		conclude();
	end
endmodule : boot_lock_and_fuse5_guard_tb

// ===== core_model.sv
`timescale 1ns/1ps
// ------------------------------
// core issuing program-memory accesses
// ------------------------------
module core_model (
	input  wire logic   i_mclk,
	input  wire logic   i_pm_block,
	input  wire logic   i_irq_mask,
	output logic [15:0] o_pm_addr,
	output logic        o_pm_store,
	output logic        o_pm_load,
	output logic        o_exec_in_boot
);
	// idle core at time zero
	initial begin
		o_pm_addr = 16'h0000;
		o_pm_store = 1'b0;
		o_pm_load = 1'b0;
		o_exec_in_boot = 1'b0;
	end

	// one access; released address flips so stale values never pass
	task automatic access(input logic [15:0] a, input logic st, input logic boot, output logic blk,
		output logic irq);
		@(posedge i_mclk);
		o_pm_addr <= a;
		o_pm_store <= st;
		o_pm_load <= !st;
		o_exec_in_boot <= boot;
		@(posedge i_mclk);
		o_pm_addr <= ~a;
		o_pm_store <= 1'b0;
		o_pm_load <= 1'b0;
		@(posedge i_mclk);
		blk = i_pm_block;
		irq = i_irq_mask;
	endtask : access
endmodule : core_model

// ===== fuse_lock_pkg.sv
package fuse_lock_pkg;

	// ----------------------------------------
	// register map (byte addresses)
	// ----------------------------------------
	localparam logic [3:0] FUSE5_OFS      = 4'h5;
	localparam logic [3:0] LOCK_OFS       = 4'h8;
	localparam logic [3:0] CTRL_OFS       = 4'hC;
	localparam logic [3:0] STATUS_OFS     = 4'h0;

	// ----------------------------------------
	// fuse byte five fields
	// ----------------------------------------
	localparam int          FUSE5_RSV_POS  = 6;
	localparam int          BOD_ACT_POS    = 4;
	localparam int          EE_KEEP_POS    = 3;
	localparam int          BOD_LVL_POS    = 0;
	localparam logic [7:0]  FUSE5_RESET    = 8'hFF;
	localparam logic [1:0]  FUSE5_RSV_ONES = 2'h3;

	// ----------------------------------------
	// lock byte fields
	// ----------------------------------------
	localparam int          BOOT_LOCK_POS  = 6;
	localparam int          APP_LOCK_POS   = 4;
	localparam int          TBL_LOCK_POS   = 2;
	localparam logic [7:0]  LOCK_RESET     = 8'hFF;
	localparam logic [7:0]  LOCK_FIELD_MSK = 8'hFC;

	// ----------------------------------------
	// control register bits
	// ----------------------------------------
	localparam int          CTRL_ERASE_BIT = 0;

	// ----------------------------------------
	// fuse write timeout
	// ----------------------------------------
	localparam int          CLK_MHZ        = 125;
	localparam int          FUSE_WR_US     = 10;
	localparam int          FUSE_WR_CYC    = FUSE_WR_US * CLK_MHZ;

	// ----------------------------------------
	// lock field codes and modes
	// ----------------------------------------
	localparam logic [1:0]  UNLOCKED_CFG           = 2'h3;
	localparam logic [1:0]  STORE_BLOCKED_CFG      = 2'h2;
	localparam logic [1:0]  LOAD_BLOCKED_CFG       = 2'h1;
	localparam logic [1:0]  STORE_LOAD_BLOCKED_CFG = 2'h0;

	localparam logic [1:0]  BOD_SAMPLED    = 2'h1;
	localparam logic [1:0]  BOD_CONTINUOUS = 2'h2;
	localparam logic [1:0]  BOD_OFF        = 2'h3;

	typedef enum logic [1:0] {
		SEC_BOOT,
		SEC_APP,
		SEC_TABLE,
		SEC_NONE
	} section_t;

endpackage : fuse_lock_pkg

// ===== fuse_timer.sv
`timescale 1ns/1ps
// counts out the fuse write timeout, pulses done at its end
module fuse_timer #(
	parameter int CYC = 1250
) (
	input  wire logic i_mclk,
	input  wire logic i_arst_n,
	input  wire logic i_start,
	output logic      o_busy,
	output logic      o_done
);
	typedef struct packed {
		logic [31:0] cnt;
		logic        busy;
		logic        done;
	} tmr_t;
	tmr_t s_r, s_nxt;

	// ----------------------------------------
	// countdown
	// ----------------------------------------
	always_comb begin
		s_nxt = s_r;
		s_nxt.done = 1'b0;
		if (i_start && !s_r.busy) begin
			s_nxt.busy = 1'b1;
			s_nxt.cnt = 32'(CYC - 1);
		end else if (s_r.busy) begin
			if (s_r.cnt == 32'h0) begin
				s_nxt.busy = 1'b0;
				s_nxt.done = 1'b1;
			end else begin
				s_nxt.cnt = s_r.cnt - 32'h1;
			end
		end
	end

	always_ff @(posedge i_mclk or negedge i_arst_n) begin
		if (!i_arst_n)
			s_r <= '0;
		else
			s_r <= s_nxt;
	end

	assign o_busy = s_r.busy;
	assign o_done = s_r.done;
endmodule : fuse_timer

// ===== guard_chk.sv
`timescale 1ns/1ps
// ------------------------------
// port checker
// ------------------------------
module guard_chk
	import fuse_lock_pkg::*;
(
	input wire logic        i_mclk,
	input wire logic        i_arst_n,
	input wire logic [3:0]  i_address,
	input wire logic        i_read,
	input wire logic        i_write,
	input wire logic [31:0] i_writedata,
	input wire logic [3:0]  i_byteenable,
	input wire logic        o_waitrequest,
	input wire logic        i_pm_store,
	input wire logic        i_pm_load,
	input wire logic        o_pm_grant,
	input wire logic        o_pm_block,
	input wire logic        o_erase_flash,
	input wire logic        o_erase_eeprom,
	input wire logic        o_erase_sram,
	input wire logic [1:0]  o_brownout_active_op,
	input wire logic        o_brownout_sampled,
	input wire logic        o_brownout_continuous
);
	// single domain, reset quiets all checks
	default clocking @(posedge i_mclk); endclocking
	default disable iff (!i_arst_n);
	chk_ack_due: assert property ((i_read | i_write) & o_waitrequest |=> !o_waitrequest)
		else $error("ack late");
	chk_pm_answer: assert property (i_pm_load | i_pm_store |=> o_pm_grant ^ o_pm_block)
		else $error("no grant or block");
	chk_pm_quiet: assert property (!(i_pm_load | i_pm_store) |=> !(o_pm_grant | o_pm_block))
		else $error("answer without request");
	chk_bod_sampled: assert property (o_brownout_sampled == (o_brownout_active_op == BOD_SAMPLED))
		else $error("sampled mode wrong");
	chk_bod_cont: assert property (o_brownout_continuous == (o_brownout_active_op == BOD_CONTINUOUS))
		else $error("continuous mode wrong");
	chk_erase_cmd: assert property (i_write & o_waitrequest & (i_address == CTRL_OFS) & i_byteenable[0]
		& i_writedata[CTRL_ERASE_BIT] |-> ##[1:2] o_erase_flash) else $error("erase missed");
	chk_erase_pair: assert property (o_erase_flash == o_erase_sram && (!o_erase_eeprom || o_erase_flash))
		else $error("erase strobes split");
	chk_erase_once: assert property (o_erase_flash |=> !o_erase_flash)
		else $error("erase not a pulse");
	cov_erase_ee: cover property (o_erase_eeprom);
	cov_block: cover property (o_pm_block);
	cov_cont: cover property (o_brownout_continuous);
endmodule : guard_chk

bind boot_lock_and_fuse5_guard guard_chk u_chk (.*);

// ===== section_decode.sv
`timescale 1ns/1ps
// classifies a program-memory access and applies the lock field of its section
module section_decode
	import fuse_lock_pkg::*;
#(
	parameter int AW = 16
) (
	input  wire logic [AW-1:0] i_addr,
	input  wire logic [AW-1:0] i_table_start,
	input  wire logic [AW-1:0] i_boot_start,
	input  wire logic [7:0]    i_lock,
	input  wire logic          i_from_boot,
	input  wire logic          i_store,
	input  wire logic          i_load,
	output logic               o_block
);
	section_t   sec;
	logic [1:0] fld;

	// ----------------------------------------
	// section select
	// ----------------------------------------
	always_comb begin
		if (i_addr >= i_boot_start)
			sec = SEC_BOOT;
		else if (i_addr >= i_table_start)
			sec = SEC_TABLE;
		else
			sec = SEC_APP;
	end

	// field bit0 low blocks stores; bit1 low blocks loads from across the boot boundary (boot vs app/table)
	always_comb begin
		fld = UNLOCKED_CFG;
		o_block = 1'b0;
		unique case (sec)
			SEC_BOOT: begin
				fld = i_lock[BOOT_LOCK_POS +: 2];
				o_block = (i_store && !fld[0])
					|| (i_load && !fld[1] && !i_from_boot);
			end
			SEC_APP: begin
				fld = i_lock[APP_LOCK_POS +: 2];
				o_block = (i_store && !fld[0])
					|| (i_load && !fld[1] && i_from_boot);
			end
			SEC_TABLE: begin
				fld = i_lock[TBL_LOCK_POS +: 2];
				o_block = (i_store && !fld[0])
					|| (i_load && !fld[1] && i_from_boot);
			end
			default: begin
				o_block = 1'b0;
			end
		endcase
	end
endmodule : section_decode
